// [hw/ixseq_classify.v]
// Opcode classifier for the indexed sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "ixseq_consts.vh"
module ixseq_classify (
    input wire [7:0] i_op,
    input wire i_pref,
    output reg [3:0] o_kind
);
    wire [3:0] hi = i_op[7:4];
    wire [3:0] lo = i_op[3:0];
    always @* begin
        o_kind = `IXSEQ_K_RD8;
        if (i_op == `IXSEQ_OP_JUMP) begin
            o_kind = `IXSEQ_K_JUMP;
        end else if (i_op == `IXSEQ_OP_TEST) begin
            o_kind = `IXSEQ_K_TST;
        end else if (i_op == `IXSEQ_OP_CALL) begin
            o_kind = `IXSEQ_K_CALL;
        end else if (i_op == `IXSEQ_OP_BIT_SET ||
                     i_op == `IXSEQ_OP_BIT_CLR) begin
            o_kind = `IXSEQ_K_BSC;
        end else if (i_op == `IXSEQ_OP_BR_SET ||
                     i_op == `IXSEQ_OP_BR_CLR) begin
            o_kind = `IXSEQ_K_BRB;
        end else if (hi == `IXSEQ_GRP_RMW) begin
            o_kind = `IXSEQ_K_RMW;
        end else if (i_op == `IXSEQ_OP_CMP_SECOND && i_pref) begin
            o_kind = `IXSEQ_K_AR16;
        end else if (lo == `IXSEQ_LO_SUBD || (lo == `IXSEQ_LO_CPX &&
                     !i_op[6]) || (lo == `IXSEQ_LO_CPX && hi[2]
                     && !i_op[6])) begin
            o_kind = `IXSEQ_K_AR16;
        end else if (lo == `IXSEQ_LO_LDD || lo == `IXSEQ_LO_LDS ||
                     lo == `IXSEQ_LO_CPX && i_op[6]) begin
            o_kind = `IXSEQ_K_LD16;
        end else if (lo == `IXSEQ_LO_STD || lo == `IXSEQ_LO_STS) begin
            o_kind = `IXSEQ_K_ST16;
        end else if (lo == `IXSEQ_LO_STA) begin
            o_kind = `IXSEQ_K_ST8;
        end
    end
endmodule
`default_nettype wire

// [hw/ixseq_consts.vh]
// Constants for the indexed-by-first-index bus-cycle sequencer.
`ifndef IXSEQ_CONSTS_VH
`define IXSEQ_CONSTS_VH
`define IXSEQ_DUMMY_ADDR 16'hFFFF
`define IXSEQ_PREFIX_A 8'h18
`define IXSEQ_PREFIX_B 8'h1A
`define IXSEQ_PREFIX_C 8'hCD
`define IXSEQ_OP_JUMP 8'h6E
`define IXSEQ_OP_TEST 8'h6D
`define IXSEQ_OP_CALL 8'hAD
`define IXSEQ_OP_BIT_SET 8'h1C
`define IXSEQ_OP_BIT_CLR 8'h1D
`define IXSEQ_OP_BR_SET 8'h1E
`define IXSEQ_OP_BR_CLR 8'h1F
`define IXSEQ_OP_STORE_SECOND 8'hEF
`define IXSEQ_OP_LOAD_SECOND 8'hEE
`define IXSEQ_OP_CMP_SECOND 8'hA3
`define IXSEQ_OP_CMP_DOUBLE 8'hA3
`define IXSEQ_HI_MASK 8'hF0
`define IXSEQ_LO_MASK 8'h0F
`define IXSEQ_GRP_RMW 4'h6
`define IXSEQ_LO_LDD 4'hC
`define IXSEQ_LO_STD 4'hD
`define IXSEQ_LO_LDS 4'hE
`define IXSEQ_LO_STS 4'hF
`define IXSEQ_LO_SUBD 4'h3
`define IXSEQ_LO_CPX 4'hC
`define IXSEQ_LO_STA 4'h7
`define IXSEQ_ONE16 16'h0001
`define IXSEQ_ZERO8 8'h00
`define IXSEQ_ZERO16 16'h0000
`define IXSEQ_K_RD8 4'h0
`define IXSEQ_K_ST8 4'h1
`define IXSEQ_K_LD16 4'h2
`define IXSEQ_K_ST16 4'h3
`define IXSEQ_K_AR16 4'h4
`define IXSEQ_K_RMW 4'h5
`define IXSEQ_K_TST 4'h6
`define IXSEQ_K_JUMP 4'h7
`define IXSEQ_K_CALL 4'h8
`define IXSEQ_K_BSC 4'h9
`define IXSEQ_K_BRB 4'hA
`endif

// [hw/ixseq_top.v]
// Bus-cycle sequencer for first-index-register addressing.
`timescale 1ns/10ps
`default_nettype none
`include "ixseq_consts.vh"
module ixseq_top (
    input wire i_clock,
    input wire i_nrst,
    input wire i_ce,
    input wire i_start,
    input wire [15:0] i_pc,
    input wire [15:0] i_first_index_register,
    input wire [15:0] i_sp,
    input wire [15:0] i_reg_data,
    input wire [7:0] i_result,
    input wire [7:0] i_rdata,
    output reg [15:0] o_addr,
    output reg o_rw,
    output reg [7:0] o_wdata,
    output reg o_busy,
    output reg o_done,
    output reg [7:0] o_opcode,
    output reg [7:0] o_offset,
    output reg [7:0] o_mask,
    output reg [7:0] o_operand
);
    localparam S_IDLE = 3'd0;
    localparam S_RUN = 3'd1;
    reg [2:0] state_q;
    reg [3:0] cyc_q;
    reg pref_q;
    reg [15:0] pc_q;
    reg [15:0] ea_q;
    wire [3:0] kind;
    // The opcode is classified from the byte on the bus in cycle one, and from o_opcode after that.
    wire [7:0] op_now = (cyc_q == 4'd1 && !pref_q) ? i_rdata : o_opcode;
    ixseq_classify u_cls (
        .i_op(op_now),
        .i_pref(pref_q),
        .o_kind(kind)
    );
    // Cycle number counted from the opcode fetch, so prefixed forms share it.
    wire [3:0] rc = pref_q ? cyc_q - 4'd1 : cyc_q;
    wire [15:0] ea_now = i_first_index_register + {`IXSEQ_ZERO8, o_offset};
    reg [15:0] a_d;
    reg rw_d;
    reg [7:0] wd_d;
    reg last_d;
    always @* begin
        a_d = `IXSEQ_DUMMY_ADDR;
        rw_d = 1'b1;
        wd_d = `IXSEQ_ZERO8;
        last_d = 1'b0;
        case (rc)
            4'd3: begin
                a_d = (kind == `IXSEQ_K_JUMP) ? i_pc : ea_now;
                rw_d = !(kind == `IXSEQ_K_ST8 || kind == `IXSEQ_K_ST16);
                wd_d = (kind == `IXSEQ_K_ST16) ? i_reg_data[15:8]
                                               : i_reg_data[7:0];
                last_d = (kind == `IXSEQ_K_RD8 || kind == `IXSEQ_K_ST8);
                if (kind == `IXSEQ_K_CALL) begin
                    a_d = ea_now;
                end
            end
            4'd4: begin
                case (kind)
                    `IXSEQ_K_LD16, `IXSEQ_K_AR16: begin
                        a_d = ea_q + `IXSEQ_ONE16;
                        last_d = (kind == `IXSEQ_K_LD16);
                    end
                    `IXSEQ_K_ST16: begin
                        a_d = ea_q + `IXSEQ_ONE16;
                        rw_d = 1'b0;
                        wd_d = i_reg_data[7:0];
                        last_d = 1'b1;
                    end
                    `IXSEQ_K_CALL: begin
                        a_d = i_sp;
                        rw_d = 1'b0;
                        wd_d = pc_q[7:0];
                    end
                    `IXSEQ_K_BSC, `IXSEQ_K_BRB: begin
                        a_d = pc_q;
                    end
                    default: a_d = `IXSEQ_DUMMY_ADDR;
                endcase
            end
            4'd5: begin
                case (kind)
                    `IXSEQ_K_RMW: begin
                        a_d = ea_q;
                        rw_d = 1'b0;
                        wd_d = i_result;
                        last_d = 1'b1;
                    end
                    `IXSEQ_K_CALL: begin
                        a_d = i_sp - `IXSEQ_ONE16;
                        rw_d = 1'b0;
                        wd_d = pc_q[15:8];
                        last_d = 1'b1;
                    end
                    // The mask cycle already advanced the program address.
                    `IXSEQ_K_BRB: a_d = pc_q;
                    default: begin
                        a_d = `IXSEQ_DUMMY_ADDR;
                        last_d = (kind != `IXSEQ_K_BSC);
                    end
                endcase
            end
            4'd6: begin
                a_d = (kind == `IXSEQ_K_BSC) ? ea_q : `IXSEQ_DUMMY_ADDR;
                rw_d = (kind != `IXSEQ_K_BSC);
                wd_d = i_result;
                last_d = 1'b1;
            end
            default: a_d = `IXSEQ_DUMMY_ADDR;
        endcase
    end
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= S_IDLE;
            cyc_q <= 4'd0;
            pref_q <= 1'b0;
            pc_q <= `IXSEQ_ZERO16;
            ea_q <= `IXSEQ_ZERO16;
            o_addr <= `IXSEQ_DUMMY_ADDR;
            o_rw <= 1'b1;
            o_wdata <= `IXSEQ_ZERO8;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_opcode <= `IXSEQ_ZERO8;
            o_offset <= `IXSEQ_ZERO8;
            o_mask <= `IXSEQ_ZERO8;
            o_operand <= `IXSEQ_ZERO8;
        end else if (i_ce) begin
            o_done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    o_rw <= 1'b1;
                    if (i_start) begin
                        state_q <= S_RUN;
                        cyc_q <= 4'd1;
                        pref_q <= 1'b0;
                        pc_q <= i_pc + `IXSEQ_ONE16;
                        o_addr <= i_pc;
                        o_busy <= 1'b1;
                    end
                end
                S_RUN: begin
                    cyc_q <= cyc_q + 4'd1;
                    if (cyc_q == 4'd1 && (i_rdata == `IXSEQ_PREFIX_A ||
                        i_rdata == `IXSEQ_PREFIX_B ||
                        i_rdata == `IXSEQ_PREFIX_C)) begin
                        pref_q <= 1'b1;
                        o_addr <= pc_q;
                        pc_q <= pc_q + `IXSEQ_ONE16;
                    end else if (rc == 4'd1) begin
                        o_opcode <= i_rdata;
                        o_addr <= pc_q;
                        pc_q <= pc_q + `IXSEQ_ONE16;
                    end else if (rc == 4'd2) begin
                        o_offset <= i_rdata;
                        o_addr <= `IXSEQ_DUMMY_ADDR;
                        if (kind == `IXSEQ_K_JUMP) begin
                            state_q <= S_IDLE;
                            o_busy <= 1'b0;
                            o_done <= 1'b1;
                        end
                    end else begin
                        if (rc == 4'd3) begin
                            ea_q <= ea_now;
                        end
                        if (rc == 4'd4 && (kind == `IXSEQ_K_BSC ||
                            kind == `IXSEQ_K_BRB)) begin
                            pc_q <= pc_q + `IXSEQ_ONE16;
                        end
                        if (rc == 4'd5 && (kind == `IXSEQ_K_BSC ||
                            kind == `IXSEQ_K_BRB)) begin
                            o_mask <= i_rdata;
                        end
                        if (rc == 4'd4) begin
                            o_operand <= i_rdata;
                        end
                        o_addr <= a_d;
                        o_rw <= rw_d;
                        o_wdata <= wd_d;
                        if (last_d) begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            if (state_q == S_RUN && o_busy && rc > 4'd2 && last_d) begin
                o_busy <= 1'b0;
                o_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/ixseq_mem.sv]
// Behavioural program and data memory on the processor bus.
`timescale 1ns/10ps
`default_nettype none
module ixseq_mem (
    input wire logic i_clock,
    input wire logic [15:0] i_addr,
    input wire logic i_rw,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:65535];
    // The read path floats while the core writes, so show a moving pattern.
    assign o_rdata = i_rw ? mem[i_addr] : ~i_addr[7:0];
    always @(posedge i_clock) begin
        if (!i_rw) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule
`default_nettype wire

// [testbench/ixseq_monitor.sv]
// Concurrent checks on the sequencer's bus outputs.
`timescale 1ns/10ps
`default_nettype none
module ixseq_monitor (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic [15:0] i_pc,
    input wire logic [15:0] o_addr,
    input wire logic o_rw,
    input wire logic o_busy,
    input wire logic o_done
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    start_addr_a: assert property (
        i_ce && i_start && !o_busy |=> o_busy && o_addr == $past(i_pc))
        else $error("First cycle not at start address.");
    offset_next_a: assert property (
        $rose(o_busy) && i_ce |=> o_addr == $past(o_addr) + 16'h0001)
        else $error("Second cycle not at next address.");
    first_read_a: assert property ($rose(o_busy) |-> o_rw)
        else $error("Opcode cycle is not a read.");
    dummy_read_a: assert property (o_addr == 16'hFFFF |-> o_rw)
        else $error("Dummy cycle is not a read.");
    idle_read_a: assert property (!o_busy && !o_done |-> o_rw)
        else $error("Write outside an instruction.");
    write_pair_a: assert property (
        i_ce && !o_rw ##1 !o_rw |-> o_addr == $past(o_addr) + 16'h0001
        || o_addr == $past(o_addr) - 16'h0001)
        else $error("Paired writes not at adjacent addresses.");
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("Done lasted more than one cycle.");
    done_bound_a: assert property ($rose(o_busy) |-> ##[2:12] o_done)
        else $error("Instruction did not finish in time.");
    freeze_addr_a: assert property (!i_ce && o_busy |=> $stable(o_addr))
        else $error("Address moved while clock enable low.");
endmodule
bind ixseq_top ixseq_monitor mon_i (.i_clock, .i_nrst, .i_ce, .i_start,
    .i_pc, .o_addr, .o_rw, .o_busy, .o_done);
`default_nettype wire

// [testbench/ixseq_top_test.sv]
// Self-checking bench for the indexed bus-cycle sequencer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ixseq_top_test;
    logic i_clock = 0, i_nrst = 0, i_ce = 1, i_start = 0, o_rw, o_busy, o_done;
    logic [15:0] i_pc = 16'h2000, i_first_index_register = 16'h3001;
    logic [15:0] i_sp = 16'h0100, i_reg_data = 16'h1234, o_addr;
    logic [7:0] i_result = 8'h5C, i_rdata, o_wdata, o_opcode, o_offset;
    logic [7:0] o_mask, o_operand;
    int n_fail = 0, cmp_count = 0;
    wire [15:0] ea = i_first_index_register + 16'h00FF;
    always #12.5 i_clock = ~i_clock;
    ixseq_top dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_start(i_start), .i_pc(i_pc),
        .i_first_index_register(i_first_index_register), .i_sp(i_sp),
        .i_reg_data(i_reg_data), .i_result(i_result), .i_rdata(i_rdata),
        .o_addr(o_addr), .o_rw(o_rw), .o_wdata(o_wdata), .o_busy(o_busy),
        .o_done(o_done), .o_opcode(o_opcode), .o_offset(o_offset),
        .o_mask(o_mask), .o_operand(o_operand));
    ixseq_mem mem_i (.i_clock(i_clock), .i_addr(o_addr), .i_rw(o_rw),
        .i_wdata(o_wdata), .o_rdata(i_rdata));
    // Letters: P program, D dummy, E/F operand, lower case are writes.
    task automatic run(input logic [7:0] pfx, op, input string s);
        logic [15:0] pc, ret, a;
        logic [7:0] d;
        logic w;
        int i, nd;
        pc = i_pc;
        ret = 16'h0000;
        nd = 0;
        if (pfx !== 8'h00) begin
            mem_i.mem[pc] = pfx;
            pc++;
        end
        mem_i.mem[pc] = op;
        mem_i.mem[pc + 1] = 8'hFF;
        mem_i.mem[pc + 2] = 8'h81;
        mem_i.mem[pc + 3] = 8'h04;
        mem_i.mem[ea] = 8'h96;
        mem_i.mem[ea + 1] = 8'h69;
        pc = i_pc;
        @(posedge i_clock) #2 i_start = 1;
        @(posedge i_clock) #2 i_start = 0;
        for (i = 0; i < s.len(); i++) begin
            w = 0;
            d = o_wdata;
            case (s[i])
                "P": begin a = pc; pc++; w = 1; end
                "D": begin a = 16'hFFFF; w = 1; if (ret === 0) ret = pc; end
                "E": begin a = ea; w = 1; end
                "F": begin a = ea + 1; w = 1; end
                "h": begin a = ea; d = i_reg_data[15:8]; end
                "l": begin a = ea + 1; d = i_reg_data[7:0]; end
                "a": begin a = ea; d = i_reg_data[7:0]; end
                "r": begin a = ea; d = i_result; end
                "s": begin a = i_sp; d = ret[7:0]; end
                default: begin a = i_sp - 1; d = ret[15:8]; end
            endcase
            `CHK({o_addr, o_rw, o_wdata}, {a, w, d})
            if (o_done === 1'b1) nd++;
            @(posedge i_clock) #2;
        end
        if (o_done === 1'b1) nd++;
        `CHK(o_busy, 1'b0)
        `CHK(nd, 1)
    endtask
    task automatic t_jump();
        run(8'h00, 8'h6E, "PPD");
        `CHK(o_offset, 8'hFF)
    endtask
    task automatic t_wide();
        run(8'h00, 8'hEC, "PPDEF");
        run(8'h1A, 8'hEE, "PPPDEF");
        run(8'h00, 8'hED, "PPDhl");
        run(8'h1A, 8'hEF, "PPPDhl");
        run(8'h00, 8'hE3, "PPDEFD");
        run(8'hCD, 8'hA3, "PPPDEFD");
    endtask
    task automatic t_call();
        run(8'h00, 8'hAD, "PPDEst");
    endtask
    task automatic t_byte();
        run(8'h00, 8'hA6, "PPDE");
        `CHK(o_operand, 8'h96)
        run(8'h00, 8'hA7, "PPDa");
        run(8'h00, 8'h6C, "PPDEDr");
        run(8'h00, 8'h6D, "PPDEDD");
    endtask
    task automatic t_bits();
        run(8'h00, 8'h1C, "PPDEPDr");
        `CHK(o_mask, 8'h81)
        run(8'h00, 8'h1D, "PPDEPDr");
        run(8'h00, 8'h1E, "PPDEPPD");
        run(8'h00, 8'h1F, "PPDEPPD");
    endtask
    task automatic t_hold();
        int i;
        @(posedge i_clock) #2 i_start = 1;
        @(posedge i_clock) #2 i_ce = 0;
        repeat (3) @(posedge i_clock);
        #2 `CHK(o_addr, i_pc)
        i_ce = 1;
        @(posedge i_clock) #2 `CHK(o_addr, i_pc + 16'h0001)
        i_start = 0;
        for (i = 0; i < 20 && o_busy !== 1'b0; i++) @(posedge i_clock);
        if (i == 20) begin
            n_fail++;
            final_report();
        end
    endtask
    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        #2 i_nrst = 1;
        t_jump();
        t_wide();
        t_call();
        t_byte();
        t_bits();
        t_hold();
        final_report();
    end
endmodule
`default_nettype wire
